// >>> src/onset_field_allocator.sv
// onset frame pitch and gain field allocator, one frame at a time
// assumes the packer and the frame source run on clk; no pin inputs
`default_nettype none

module onset_field_allocator (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	input wire onset_alloc_pkg::frame_t frame_in,
	input wire onset_alloc_pkg::sub_t sub_in [onset_alloc_pkg::MAX_SUB],
	input wire logic field_ready,
	output onset_alloc_pkg::field_t field,
	output logic field_valid,
	output logic busy,
	output logic done
);
	import onset_alloc_pkg::*;

	typedef enum {S_IDLE, S_CODE, S_PITCH, S_DIV, S_CORR, S_GAIN, S_DONE}
		state_t;

	state_t state;
	state_t next_state;
	frame_t frm;
	sub_t subs [MAX_SUB];
	logic [2:0] sf;
	logic [2:0] next_sf;
	field_t next_field;
	logic next_valid;
	logic go_sub;
	logic go_gain;
	logic [24:0] rem;
	logic [31:0] dvd;
	logic [31:0] quo;
	logic [5:0] cnt;

	// a plan entry for one lag field
	function automatic plan_t lag_plan(lag_range_t r, logic [3:0] w);
		plan_t p;
		p.range = r;
		p.lag_w = w;
		p.alg_only = 1'b0;
		p.force_sq = 1'b0;
		return p;
	endfunction

	// what one subframe carries for a given configuration
	function automatic plan_t sub_plan(frame_t f, logic [2:0] s);
		plan_t p;
		plan_t alg;
		logic [3:0] dw;
		int c;
		int a;
		alg = lag_plan(RANGE_NONE, 4'h0);
		alg.alg_only = 1'b1;
		p = lag_plan(RANGE_NONE, 4'h0);
		dw = f.delta6 ? DELTA_HI_W : DELTA_LO_W;
		c = int'(f.cfg);
		a = (c > 2) ? c : 2;
		if (f.wide) begin
			if (int'(s) < c) begin
				p = alg;
			end else if (int'(s) == a) begin
				p = lag_plan(RANGE_ABS, ABS10_W);
				p.force_sq = (c == WIDE_CFG_COUNT - 1);
			end else if (int'(s) > a) begin
				p = lag_plan(RANGE_DELTA, DELTA_HI_W);
			end else if (s == 3'h0 || c == 1) begin
				p = lag_plan(RANGE_W1, W1_W);
			end else begin
				p = lag_plan(RANGE_W2, W2_W);
			end
		end else begin
			case (onset_cfg_t'(f.cfg))
				ONSET_CFG_A: begin
					if (s == 3'h0)
						p = lag_plan(RANGE_A1, A1_W);
					else
						p = lag_plan(RANGE_DELTA, dw);
				end
				ONSET_CFG_B: begin
					if (s == 3'h1)
						p = lag_plan(RANGE_B2, B2_W);
					else if (s > 3'h1)
						p = lag_plan(RANGE_DELTA, DELTA_HI_W);
				end
				ONSET_CFG_C: begin
					if (s == 3'h1)
						p = alg;
					else if (s == 3'h2)
						p = lag_plan(RANGE_C3, C3_W);
					else if (s == 3'h3)
						p = lag_plan(RANGE_DELTA, dw);
				end
				ONSET_CFG_D: begin
					if (s == 3'h1 || s == 3'h2)
						p = alg;
					else if (s == 3'h3)
						p = lag_plan(RANGE_D4, D4_W);
				end
				ONSET_CFG_E: begin
					if (s == 3'h0)
						p = alg;
					else if (s == 3'h2)
						p = lag_plan(RANGE_ABS, ABS9_W);
					else if (s == 3'h3)
						p = lag_plan(RANGE_DELTA, dw);
				end
				ONSET_CFG_F: begin
					if (s < 3'h2)
						p = alg;
					else if (s == 3'h2)
						p = lag_plan(RANGE_ABS, F3_W);
					else
						p = lag_plan(RANGE_ABS, ABS9_W);
				end
				default: begin
					// code 7 is illegal and is treated as the last config
					if (s < 3'h3) begin
						p = alg;
					end else begin
						p = lag_plan(RANGE_ABS, ABS9_W);
						p.force_sq = 1'b1;
					end
				end
			endcase
		end
		return p;
	endfunction

	// lag field value: clamp to the allowed range, offset from its floor
	function automatic logic [15:0] pitch_value(plan_t p, sub_t s,
		frame_t f);
		int n;
		int k;
		int lo;
		int hi;
		int lag;
		int v;
		int top;
		n = int'(f.sub_len);
		k = int'(f.pulse_pos);
		lo = 0;
		hi = 0;
		case (p.range)
			RANGE_A1: begin
				lo = A1_LAG_MIN;
				hi = n;
			end
			RANGE_B2: begin
				lo = (n - k < A1_LAG_MIN) ? n - k : A1_LAG_MIN;
				hi = 2 * n - 1 - k;
			end
			RANGE_C3: begin
				lo = 2 * n - 1 - k;
				hi = 3 * n - 1 - k;
			end
			RANGE_D4: begin
				lo = 3 * n - k;
				hi = D4_LAG_MAX;
			end
			RANGE_W1: begin
				lo = WIDE_LAG_MIN;
				hi = n;
			end
			RANGE_W2: begin
				lo = WIDE_LAG_MIN;
				hi = 2 * n;
			end
			default: begin
				lo = ABS_LAG_MIN;
				hi = ABS_LAG_MAX;
			end
		endcase
		top = (1 << p.lag_w) - 1;
		if (p.range == RANGE_DELTA) begin
			v = int'(s.delta_idx);
		end else begin
			lag = int'(s.lag_half);
			lo = lo << LAG_FRAC_SHIFT;
			hi = hi << LAG_FRAC_SHIFT;
			if (hi < lo)
				hi = lo;
			if (lag < lo)
				lag = lo;
			if (lag > hi)
				lag = hi;
			v = lag - lo;
		end
		if (v > top)
			v = top;
		if (v < 0)
			v = 0;
		return v[15:0];
	endfunction

	// gain field when no search is needed
	function automatic field_t gain_field(plan_t p, sub_t s, frame_t f);
		field_t g;
		g.kind = FIELD_GAIN;
		if (p.alg_only) begin
			g.width = ALG_HI_W;
			g.value = {10'h000, s.alg_sq_idx};
		end else if (p.force_sq || f.hi_rate) begin
			g.width = GAIN_SQ_W;
			g.value = {4'h0, s.sq_idx};
		end else begin
			g.width = GAIN_VQ_W;
			g.value = {10'h000, s.vq_idx};
		end
		return g;
	endfunction

	// configuration prefix code
	function automatic field_t code_field(frame_t f);
		field_t c;
		int i;
		c.kind = FIELD_CFG;
		if (f.wide) begin
			i = (int'(f.cfg) < WIDE_CFG_COUNT) ? int'(f.cfg) :
				WIDE_CFG_COUNT - 1;
			c.width = WIDE_CODE_LEN[i];
			c.value = {12'h000, WIDE_CODE[i]};
		end else begin
			i = (f.cfg == 3'h7) ? 6 : int'(f.cfg);
			c.width = NARROW_CODE_LEN[i];
			c.value = {12'h000, NARROW_CODE[i]};
		end
		return c;
	endfunction

	function automatic logic [2:0] count_ones(logic [6:0] v);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < 7; i++)
			n = n + {2'h0, v[i]};
		return n;
	endfunction

	// plans for the current and the following subframe
	logic [2:0] nxt_sub;
	plan_t plan_c;
	plan_t plan_n;
	plan_t plan_g;
	sub_t sub_g;
	logic last_sub;
	logic need_div;
	assign nxt_sub = (state == S_CODE) ? 3'h0 : sf + 3'h1;
	assign plan_c = sub_plan(frm, sf);
	assign plan_n = sub_plan(frm, nxt_sub);
	assign plan_g = go_sub ? plan_n : plan_c;
	assign sub_g = go_sub ? subs[nxt_sub] : subs[sf];
	assign last_sub = sf == (frm.wide ? WIDE_LAST_SUB : NARROW_LAST_SUB);
	// the wide high rate sends the upstream 6-bit index, no search
	assign need_div = plan_g.alg_only && !(frm.wide && frm.hi_rate);

	// restoring division, one quotient bit per clock
	logic [25:0] den;
	logic [25:0] rem_sh;
	logic fits;
	logic [25:0] next_rem;
	logic [31:0] dividend;
	logic [15:0] g_opt;
	assign den = 26'(subs[sf].zz) + 26'(ENERGY_OFFSET_Q);
	assign rem_sh = {rem, dvd[31]};
	assign fits = rem_sh >= den;
	assign next_rem = fits ? rem_sh - den : rem_sh;
	// a negative correlation gives zero gain rather than a signed quotient
	assign dividend = subs[next_sf].xz[23] ? 32'h0 :
		{subs[next_sf].xz, 8'h00};
	assign g_opt = (|quo[31:16]) ? 16'hFFFF : quo[15:0];

	// midpoint thresholds scaled by the predicted gain
	logic [6:0] above;
	logic [2:0] corr_idx;
	genvar gi;
	generate
		for (gi = 0; gi < CORR_ENTRIES - 1; gi++) begin : g_thr
			logic [16:0] mid;
			logic [31:0] prod;
			assign mid = ({1'b0, CORR_TABLE[gi]} +
				{1'b0, CORR_TABLE[gi + 1]}) >> 1;
			assign prod = {16'h0000, mid[15:0]} *
				{16'h0000, subs[sf].pred_gain};
			assign above[gi] = {4'h0, g_opt} >=
				prod[TABLE_FRAC +: 20];
		end
	endgenerate
	assign corr_idx = count_ones(above);

	// sequencing of code, lag and gain fields
	always_comb begin
		next_state = state;
		next_sf = sf;
		next_field = field;
		next_valid = field_valid;
		go_sub = 1'b0;
		go_gain = 1'b0;
		unique case (state)
			S_IDLE: begin
				if (start) begin
					next_state = S_CODE;
					next_field = code_field(frame_in);
					next_valid = 1'b1;
					next_sf = 3'h0;
				end
			end
			S_CODE: begin
				if (field_ready) begin
					next_valid = 1'b0;
					go_sub = 1'b1;
				end
			end
			S_PITCH: begin
				if (field_ready) begin
					next_valid = 1'b0;
					go_gain = 1'b1;
				end
			end
			S_GAIN: begin
				if (field_ready) begin
					next_valid = 1'b0;
					if (last_sub)
						next_state = S_DONE;
					else
						go_sub = 1'b1;
				end
			end
			S_DIV: begin
				if (cnt == DIV_LAST)
					next_state = S_CORR;
			end
			S_CORR: begin
				next_state = S_GAIN;
				next_field = '{FIELD_GAIN, CORR_W, {13'h0000, corr_idx}};
				next_valid = 1'b1;
			end
			S_DONE: begin
				next_state = S_IDLE;
			end
		endcase
		if (go_sub) begin
			next_sf = nxt_sub;
			if (plan_n.lag_w != 4'h0) begin
				next_state = S_PITCH;
				next_field = '{FIELD_PITCH, plan_n.lag_w,
					pitch_value(plan_n, subs[nxt_sub], frm)};
				next_valid = 1'b1;
			end else begin
				go_gain = 1'b1;
			end
		end
		if (go_gain) begin
			if (need_div) begin
				next_state = S_DIV;
			end else begin
				next_state = S_GAIN;
				next_field = gain_field(plan_g, sub_g, frm);
				next_valid = 1'b1;
			end
		end
	end

	// control and output registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= S_IDLE;
			sf <= 3'h0;
			field <= '{FIELD_CFG, 4'h0, 16'h0000};
			field_valid <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			state <= next_state;
			sf <= next_sf;
			field <= next_field;
			field_valid <= next_valid;
			busy <= next_state != S_IDLE;
			done <= next_state == S_DONE;
		end
	end

	// frame parameters are caught once so the source may move on
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			frm <= '0;
			for (int i = 0; i < MAX_SUB; i++)
				subs[i] <= '0;
		end else if (state == S_IDLE && start) begin
			frm <= frame_in;
			for (int i = 0; i < MAX_SUB; i++)
				subs[i] <= sub_in[i];
		end
	end

	// divider state; loaded on entry, stepped while dividing
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rem <= '0;
			dvd <= '0;
			quo <= '0;
			cnt <= '0;
		end else if (next_state == S_DIV && state != S_DIV) begin
			rem <= '0;
			dvd <= dividend;
			quo <= '0;
			cnt <= '0;
		end else if (state == S_DIV) begin
			rem <= next_rem[24:0];
			dvd <= {dvd[30:0], 1'b0};
			quo <= {quo[30:0], fits};
			cnt <= cnt + 6'h1;
		end
	end

endmodule

`default_nettype wire

// >>> src/onset_alloc_pkg.sv
// constants, types and field layouts for the onset field allocator
// assumes a single 40 MHz frame-processing clock shared with the packer
`default_nettype none

package onset_alloc_pkg;

	localparam int MAX_SUB = 5;
	localparam logic [2:0] NARROW_LAST_SUB = 3'h3;
	localparam logic [2:0] WIDE_LAST_SUB = 3'h4;

	// lag limits in whole samples; lags arrive in half-sample units
	localparam int LAG_FRAC_SHIFT = 1;
	localparam int A1_LAG_MIN = 34;
	localparam int WIDE_LAG_MIN = 42;
	localparam int D4_LAG_MAX = 231;
	localparam int ABS_LAG_MIN = 34;
	localparam int ABS_LAG_MAX = 231;

	// field widths in bits
	localparam logic [3:0] A1_W = 4'h6;
	localparam logic [3:0] B2_W = 4'h7;
	localparam logic [3:0] C3_W = 4'h7;
	localparam logic [3:0] D4_W = 4'h7;
	localparam logic [3:0] F3_W = 4'h5;
	localparam logic [3:0] ABS9_W = 4'h9;
	localparam logic [3:0] W1_W = 4'h6;
	localparam logic [3:0] W2_W = 4'h8;
	localparam logic [3:0] ABS10_W = 4'hA;
	localparam logic [3:0] DELTA_LO_W = 4'h5;
	localparam logic [3:0] DELTA_HI_W = 4'h6;
	localparam logic [3:0] GAIN_VQ_W = 4'h6;
	localparam logic [3:0] GAIN_SQ_W = 4'hC;
	localparam logic [3:0] CORR_W = 4'h3;
	localparam logic [3:0] ALG_HI_W = 4'h6;

	// configuration prefix codes, sent msb first, right aligned
	localparam logic [3:0] NARROW_CODE [7] = '{4'h1, 4'h5, 4'h4, 4'h3,
		4'h1, 4'h1, 4'h0};
	localparam logic [3:0] NARROW_CODE_LEN [7] = '{4'h1, 4'h4, 4'h4,
		4'h3, 4'h3, 4'h4, 4'h4};
	localparam logic [3:0] WIDE_CODE [5] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'h7};
	localparam logic [3:0] WIDE_CODE_LEN [5] = '{4'h2, 4'h2, 4'h2, 4'h3,
		4'h3};
	localparam int WIDE_CFG_COUNT = 5;

	// correction-factor search: gain = xz / (offset + zz)
	localparam real GAIN_OFFSET = 0.01;
	localparam int ENERGY_FRAC = 12;
	localparam int ENERGY_OFFSET_Q = int'(GAIN_OFFSET * 4096.0);
	localparam int GAIN_FRAC = 8;
	localparam int DIV_STEPS = 32;
	localparam logic [5:0] DIV_LAST = 6'h1F;
	localparam int TABLE_FRAC = 12;
	localparam int CORR_ENTRIES = 8;
	localparam logic [15:0] CORR_TABLE [CORR_ENTRIES] = '{16'h0200,
		16'h0400, 16'h0600, 16'h0800, 16'h0A00, 16'h0C00, 16'h0E00,
		16'h1000};

	typedef enum logic [2:0] {ONSET_CFG_A, ONSET_CFG_B, ONSET_CFG_C,
		ONSET_CFG_D, ONSET_CFG_E, ONSET_CFG_F, ONSET_CFG_G} onset_cfg_t;
	typedef enum logic [1:0] {FIELD_CFG, FIELD_PITCH, FIELD_GAIN}
		field_kind_t;
	typedef enum logic [3:0] {RANGE_NONE, RANGE_A1, RANGE_B2, RANGE_C3,
		RANGE_D4, RANGE_ABS, RANGE_W1, RANGE_W2, RANGE_DELTA} lag_range_t;

	typedef struct packed {
		logic wide;
		logic [2:0] cfg;
		logic hi_rate;
		logic delta6;
		logic [7:0] pulse_pos;
		logic [7:0] sub_len;
	} frame_t;

	typedef struct packed {
		logic [9:0] lag_half;
		logic [5:0] delta_idx;
		logic [5:0] vq_idx;
		logic [11:0] sq_idx;
		logic [5:0] alg_sq_idx;
		logic signed [23:0] xz;
		logic [23:0] zz;
		logic [15:0] pred_gain;
	} sub_t;

	typedef struct packed {
		field_kind_t kind;
		logic [3:0] width;
		logic [15:0] value;
	} field_t;

	typedef struct packed {
		lag_range_t range;
		logic [3:0] lag_w;
		logic alg_only;
		logic force_sq;
	} plan_t;

endpackage

`default_nettype wire

// >>> verif/onset_alloc_sva.sv
// port protocol checker for the onset field allocator
// assumes it is bound into onset_field_allocator, one clock, rst_b low
`default_nettype none

module onset_alloc_sva
	import onset_alloc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic field_ready,
	input wire onset_alloc_pkg::field_t field,
	input wire logic field_valid,
	input wire logic busy,
	input wire logic done
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// an accept ends a field; the correction search is the slowest follower
	wire logic acc = field_valid && field_ready;

	a_code_first: assert property (start && !busy |=>
		field_valid && field.kind == FIELD_CFG) else $error("no code at start");
	a_field_held: assert property (field_valid && !field_ready |=>
		field_valid && $stable(field)) else $error("field dropped unaccepted");
	// fields may follow back to back, but the code never comes twice
	a_code_once: assert property (acc |=>
		!(field_valid && field.kind == FIELD_CFG))
		else $error("code repeated inside a frame");
	a_next_soon: assert property (acc |-> ##[1:35] (field_valid || done))
		else $error("next field late");
	a_done_once: assert property (done |=> !done && !busy)
		else $error("done not a single pulse");
	a_valid_busy: assert property (field_valid |-> busy)
		else $error("field while idle");
	a_gain_width: assert property (field_valid && field.kind == FIELD_GAIN |->
		field.width inside {4'h3, 4'h6, 4'hC})
		else $error("bad gain width");
	a_lag_width: assert property (field_valid && field.kind == FIELD_PITCH |->
		field.width inside {[4'h5:4'hA]})
		else $error("bad lag width");
	a_value_fits: assert property (field_valid |->
		(field.value >> field.width) == 16'h0) else $error("value too wide");
	a_short_code: assert property (field_valid && field.kind == FIELD_CFG &&
		field.width == 4'h1 |-> field.value == 16'h1)
		else $error("one-bit code not 1");
endmodule

bind onset_field_allocator onset_alloc_sva chk (.clk(clk), .rst_b(rst_b),
	.start(start), .field_ready(field_ready), .field(field),
	.field_valid(field_valid), .busy(busy), .done(done));

`default_nettype wire

// >>> verif/field_packer_model.sv
// bitstream packer model: accepts fields, stalling at random when asked
// assumes the allocator holds each field until it is accepted
`default_nettype none

module field_packer_model
	import onset_alloc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire onset_alloc_pkg::field_t field,
	input wire logic field_valid,
	input wire logic stall,
	output logic field_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	field_t got[$];

	initial field_ready = 1'b0;
	// ready moves on the falling edge, clear of the sampling edge
	always @(negedge clk)
		field_ready <= stall ? 1'($urandom_range(1)) : 1'b1;
	// fields are stored in arrival order, code first
	always @(posedge clk)
		if (rst_b && field_valid && field_ready)
			got.push_back(field);
endmodule

`default_nettype wire

// >>> verif/test_onset_field_allocator.sv
// bench for the onset field allocator: every configuration, random data
// assumes field_packer_model as the packer and a 40 MHz clock
`default_nettype none

module test_onset_field_allocator
	import onset_alloc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic start = 1'b0;
	logic stall = 1'b0;
	frame_t frame_in = '0;
	sub_t sub_in [MAX_SUB] = '{default: '0};
	field_t field;
	logic field_ready;
	logic field_valid;
	logic busy;
	logic done;
	field_t exp_q[$];
	int mismatches = 0;
	int checks = 0;
	int cycles = 0;
	int ncode [7] = '{1, 5, 4, 3, 1, 1, 0};
	int nlen [7] = '{1, 4, 4, 3, 3, 4, 4};
	int wcode [5] = '{0, 1, 2, 6, 7};
	int wlen [5] = '{2, 2, 2, 3, 3};

	onset_field_allocator dut (.clk(clk), .rst_b(rst_b), .start(start),
		.frame_in(frame_in), .sub_in(sub_in), .field_ready(field_ready),
		.field(field), .field_valid(field_valid), .busy(busy), .done(done));
	field_packer_model pk (.clk(clk), .rst_b(rst_b), .field(field),
		.field_valid(field_valid), .stall(stall), .field_ready(field_ready));

	always #12.5 clk = ~clk;

	// a hung handshake ends the run here
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			stop_test();
		end
	end

	task automatic stop_test();
		if (mismatches == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, e, g);
		end
	endtask

	function automatic field_t fld(field_kind_t k, int w, int v);
		return '{k, 4'(w), 16'(v)};
	endfunction

	function automatic int sat(int v, int w);
		return (v > (1 << w) - 1) ? (1 << w) - 1 : v;
	endfunction

	// lag clamped into its range, offset from the low end
	function automatic int pval(int lag, lo, hi, w);
		if (hi < lo)
			hi = lo;
		if (lag < 2 * lo)
			lag = 2 * lo;
		if (lag > 2 * hi)
			lag = 2 * hi;
		return sat(lag - 2 * lo, w);
	endfunction

	// correction index: table midpoints scaled by the predicted gain
	function automatic int corr(sub_t s);
		longint g;
		int idx;
		g = (s.xz < 0) ? 0 : (longint'(s.xz) * 256) / (s.zz + 41);
		if (g > 65535)
			g = 65535;
		idx = 0;
		for (int i = 0; i < 7; i++)
			if (g >= ((((CORR_TABLE[i] + CORR_TABLE[i + 1]) >> 1) *
				s.pred_gain) >> 12))
				idx++;
		return idx;
	endfunction

	// lag width, range and gain kind (0 pair, 1 algebraic, 2 scalar)
	task automatic slot(input int sf, c, n, k, output int w, lo, hi, g,
		output logic dl);
		int d;
		d = frame_in.delta6 ? 6 : 5;
		w = 0;
		lo = 34;
		hi = 231;
		g = 0;
		dl = 1'b0;
		if (frame_in.wide) begin
			if (sf < c)
				g = 1;
			else if (sf == (c > 2 ? c : 2))
				w = 10;
			else if (sf > 2 && sf > c) begin
				w = 6;
				dl = 1'b1;
			end else begin
				w = (sf == 1 && c == 0) ? 8 : 6;
				lo = 42;
				hi = (w == 8) ? 2 * n : n;
			end
			if (c == 4 && sf == 4)
				g = 2;
		end else
			case (c)
			0: begin
				w = (sf == 0) ? 6 : d;
				hi = n;
				dl = sf != 0;
			end
			1: if (sf == 1) begin
				w = 7;
				lo = (n - k < 34) ? n - k : 34;
				hi = 2 * n - 1 - k;
			end else if (sf > 1) begin
				w = 6;
				dl = 1'b1;
			end
			2: if (sf == 1)
				g = 1;
			else if (sf == 2) begin
				w = 7;
				lo = 2 * n - 1 - k;
				hi = 3 * n - 1 - k;
			end else if (sf == 3) begin
				w = d;
				dl = 1'b1;
			end
			3: if (sf == 1 || sf == 2)
				g = 1;
			else if (sf == 3) begin
				w = 7;
				lo = 3 * n - k;
			end
			4: if (sf == 0)
				g = 1;
			else if (sf > 1) begin
				w = (sf == 2) ? 9 : d;
				dl = sf == 3;
			end
			5: if (sf < 2)
				g = 1;
			else
				w = (sf == 2) ? 5 : 9;
			default: if (sf < 3)
				g = 1;
			else begin
				w = 9;
				g = 2;
			end
			endcase
	endtask

	// expected field stream of the frame now on the inputs
	task automatic build();
		int c, ci, w, lo, hi, g;
		logic dl;
		sub_t s;
		c = frame_in.cfg;
		// illegal codes are sent as the last configuration of their width
		ci = frame_in.wide ? (c > 4 ? 4 : c) : (c > 6 ? 6 : c);
		exp_q = {};
		if (frame_in.wide)
			exp_q.push_back(fld(FIELD_CFG, wlen[ci], wcode[ci]));
		else
			exp_q.push_back(fld(FIELD_CFG, nlen[ci], ncode[ci]));
		for (int sf = 0; sf < (frame_in.wide ? 5 : 4); sf++) begin
			s = sub_in[sf];
			slot(sf, c, frame_in.sub_len, frame_in.pulse_pos, w, lo, hi, g, dl);
			if (w > 0)
				exp_q.push_back(fld(FIELD_PITCH, w, dl ? sat(s.delta_idx, w) :
					pval(s.lag_half, lo, hi, w)));
			if (g == 2 || (g == 0 && frame_in.hi_rate))
				exp_q.push_back(fld(FIELD_GAIN, 12, s.sq_idx));
			else if (g == 0)
				exp_q.push_back(fld(FIELD_GAIN, 6, s.vq_idx));
			else if (frame_in.wide && frame_in.hi_rate)
				exp_q.push_back(fld(FIELD_GAIN, 6, s.alg_sq_idx));
			else
				exp_q.push_back(fld(FIELD_GAIN, 3, corr(s)));
		end
	endtask

	task automatic rand_frame(input int c);
		frame_in = frame_t'(22'($urandom));
		frame_in.wide = c > 6;
		frame_in.cfg = 3'(c > 6 ? c - 7 : c);
		frame_in.sub_len = 8'(40 + $urandom_range(87));
		frame_in.pulse_pos = 8'($urandom_range(frame_in.sub_len - 1));
		stall = 1'($urandom);
		foreach (sub_in[i]) begin
			sub_in[i] = sub_t'(104'({$urandom, $urandom, $urandom, $urandom}));
			sub_in[i].zz >>= $urandom_range(20);
			sub_in[i].pred_gain >>= $urandom_range(12);
			if ($urandom_range(3) == 0)
				sub_in[i].lag_half = {10{1'($urandom)}};
		end
	endtask

	// start at the first idle edge; optionally a start while busy
	task automatic run_frame(input logic again);
		int t;
		build();
		pk.got = {};
		start = 1'b1;
		@(negedge clk) start = 1'b0;
		check("busy", 1, busy);
		if (again) begin
			repeat (3) @(negedge clk);
			frame_in.cfg ^= 3'h1;
			start = 1'b1;
			@(negedge clk) start = 1'b0;
		end
		t = 0;
		while (done !== 1'b1 && t < 3000) begin
			@(negedge clk);
			t++;
		end
		check("done", 1, done);
		@(negedge clk);
		check("idle", 0, busy);
		check("field count", exp_q.size(), pk.got.size());
		foreach (exp_q[i])
			if (i < pk.got.size())
				check("field", exp_q[i], pk.got[i]);
	endtask

	initial begin
		void'($urandom(32'h379C2C21));
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		// every configuration at both rates, then random ones
		for (int i = 0; i < 34; i++) begin
			rand_frame(i < 24 ? i % 12 : $urandom_range(11));
			if (i < 24)
				frame_in.hi_rate = 1'(i / 12);
			run_frame(i % 5 == 2);
		end
		// reset in mid-frame clears the outputs at once
		rand_frame(0);
		start = 1'b1;
		@(negedge clk) start = 1'b0;
		repeat (4) @(negedge clk);
		rst_b = 1'b0;
		#1 check("reset outputs", 0, {field_valid, busy, done});
		@(negedge clk) rst_b = 1'b1;
		rand_frame(6);
		run_frame(1'b0);
		// illegal codes: narrow 7 acts as cfg g, wide 6 as all algebraic
		rand_frame(6);
		frame_in.cfg = 3'h7;
		run_frame(1'b0);
		rand_frame(11);
		frame_in.cfg = 3'h6;
		run_frame(1'b0);
		stop_test();
	end
endmodule

`default_nettype wire
